// *** verilog/rpp_params.svh ***
// Constants for the reduced-pin port configuration block
`ifndef RPP_PARAMS_SVH
`define RPP_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_P0_DATA 8'h02
`define IDX_P1_DATA 8'h03
`define IDX_P0_DIR 8'h04
`define IDX_P1_DIR 8'h05
`define IDX_P2_DATA 8'h06
`define IDX_P3_DATA 8'h07
`define IDX_P2_DIR 8'h08
`define IDX_P3_DIR 8'h09
`define IDX_P4_DATA 8'h0a
`define IDX_P5_DATA 8'h0b
`define IDX_P4_DIR 8'h0c
`define IDX_P5_DIR 8'h0d
`define IDX_P6_DATA 8'h0e
`define IDX_P7_DATA 8'h0f
`define IDX_P6_DIR 8'h10
`define IDX_P7_DIR 8'h11
`define IDX_P8_DATA 8'h12
`define IDX_P8_DIR 8'h14
`define IDX_ADC_CONTROL 8'h1e
`define IDX_ADC_RESULT_BASE 8'h20
`define IDX_ADC_RESULT_LAST 8'h2f
`define IDX_SERIAL1_MODE 8'h38
`define IDX_SERIAL1_CONTROL0 8'h3c

// ****************************************************************
// Pin and write masks per port, reset values
// ****************************************************************
`define MASK_ALL 8'hff
`define P3_PIN_MASK 8'h07
`define P3_WR_MASK 8'h0f
`define P4_PIN_MASK 8'h87
`define P6_PIN_MASK 8'h3c
`define P7_PIN_MASK 8'h87
`define P8_PIN_MASK 8'hcf
`define DIR_RESET 8'h00
`define DATA_RESET 8'h00
`define CFG_RESET 8'h00
`define ADC_UNDEF_VALUE 8'h00
`define ADC_CH_FIRST_MISSING 3'h3
`define ADC_CH_LAST_MISSING 3'h6

// ****************************************************************
// Bus constants
// ****************************************************************
`define AXI_ADDR_W 12
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`define NUM_PORTS 9

`endif

// *** verilog/rpp_pkg.sv ***
// Types shared by the reduced-pin port configuration block
package rpp_pkg;

  // Drive of one 8-bit port: level and enable per pin
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe;
  } pin_drive_s;

  // Configuration seen by neighbouring peripherals
  typedef struct packed {
    logic [7:0] adc_control;
    logic [7:0] serial1_mode;
    logic [7:0] serial1_control0;
  } periph_cfg_s;

  // Write channel states
  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } wr_state_e;

  // Read channel states
  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_RESP = 2'b10
  } rd_state_e;

endpackage : rpp_pkg

// *** verilog/dir_port.sv ***
// One 8-bit port: direction and data registers with pin masking
`timescale 1ns/1ns
`include "rpp_params.svh"

module dir_port
  import rpp_pkg::*;
#(
  parameter logic [7:0] PIN_MASK = 8'hff,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  input wire logic dir_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  // Pins
  input wire logic [7:0] pin_in,
  output pin_drive_s pins,
  // Register reads
  output logic [7:0] dir_rd,
  output logic [7:0] data_rd
);

  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;

  // Next values; unwritable bits never leave their reset value
  always_comb begin
    dir_next = dir_reg;
    data_next = data_reg;
    if (dir_we) begin
      dir_next = wdata & WR_MASK;
    end
    if (data_we) begin
      data_next = wdata & WR_MASK;
    end
  end

  // State registers, all cleared on reset so every pin starts as input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= `DIR_RESET;
      data_reg <= `DATA_RESET;
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
    end
  end

  // Only bonded pins are driven; missing pins keep their stored bit
  assign pins.oe = dir_reg & PIN_MASK;
  assign pins.value = data_reg & PIN_MASK;

  // Direction reads show the stored bits; masked-off bits read zero
  assign dir_rd = dir_reg & WR_MASK;
  // Input bits show the pin, output bits the latch
  assign data_rd = ((dir_reg & data_reg) | (~dir_reg & pin_in & PIN_MASK)) & WR_MASK;

endmodule : dir_port

// *** verilog/reduced_pin_port_config.sv ***
// Reduced-pin port configuration block with an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rpp_params.svh"

module reduced_pin_port_config
  import rpp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Port pins, index 0 to 8
  input wire logic [`NUM_PORTS-1:0][7:0] port_pin_in,
  output pin_drive_s [`NUM_PORTS-1:0] port_pins,
  // Converter results, one byte per analog channel
  input wire logic [7:0][7:0] adc_result_in,
  // Configuration to neighbouring peripherals
  output periph_cfg_s periph_cfg,
  // Bus hold acknowledge, absent on this package
  output logic hold_acknowledge_out
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************

  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Release through two flops so logic leaves reset on a clean edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Port instances
  // ****************************************************************

  localparam logic [`NUM_PORTS-1:0][7:0] PIN_MASKS = {
    `P8_PIN_MASK, `P7_PIN_MASK, `P6_PIN_MASK, `MASK_ALL, `P4_PIN_MASK,
    `P3_PIN_MASK, `MASK_ALL, `MASK_ALL, `MASK_ALL
  };
  localparam logic [`NUM_PORTS-1:0][7:0] WR_MASKS = {
    `MASK_ALL, `MASK_ALL, `MASK_ALL, `MASK_ALL, `MASK_ALL,
    `P3_WR_MASK, `MASK_ALL, `MASK_ALL, `MASK_ALL
  };
  localparam logic [`NUM_PORTS-1:0][7:0] DIR_IDX = {
    `IDX_P8_DIR, `IDX_P7_DIR, `IDX_P6_DIR, `IDX_P5_DIR, `IDX_P4_DIR,
    `IDX_P3_DIR, `IDX_P2_DIR, `IDX_P1_DIR, `IDX_P0_DIR
  };
  localparam logic [`NUM_PORTS-1:0][7:0] DATA_IDX = {
    `IDX_P8_DATA, `IDX_P7_DATA, `IDX_P6_DATA, `IDX_P5_DATA, `IDX_P4_DATA,
    `IDX_P3_DATA, `IDX_P2_DATA, `IDX_P1_DATA, `IDX_P0_DATA
  };

  logic wr_go;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic [`NUM_PORTS-1:0] dir_we;
  logic [`NUM_PORTS-1:0] data_we;
  logic [`NUM_PORTS-1:0][7:0] dir_rd;
  logic [`NUM_PORTS-1:0][7:0] data_rd;

  // Missing pins are never driven, so a stray one from software is harmless
  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    assign dir_we[p] = wr_go && (wr_idx == DIR_IDX[p]);
    assign data_we[p] = wr_go && (wr_idx == DATA_IDX[p]);
    dir_port #(
      .PIN_MASK(PIN_MASKS[p]),
      .WR_MASK(WR_MASKS[p])
    ) u_port (
      .clk(mclk),
      .rst_n(rst_n),
      .dir_we(dir_we[p]),
      .data_we(data_we[p]),
      .wdata(wr_byte),
      .pin_in(port_pin_in[p]),
      .pins(port_pins[p]),
      .dir_rd(dir_rd[p]),
      .data_rd(data_rd[p])
    );
  end

  // The hold handshake has no pin, so the signal stays inactive
  assign hold_acknowledge_out = 1'b0;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Byte address to register index; high bits beyond the map are unmapped
  function automatic logic [7:0] addr_idx(input logic [`AXI_ADDR_W-1:0] a);
    addr_idx = a[9:2];
  endfunction : addr_idx

  function automatic logic addr_hit(input logic [`AXI_ADDR_W-1:0] a);
    logic [7:0] i;
    logic hit;
    i = a[9:2];
    hit = 1'b0;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (i == DIR_IDX[p] || i == DATA_IDX[p]) begin
        hit = 1'b1;
      end
    end
    if (i == `IDX_ADC_CONTROL || i == `IDX_SERIAL1_MODE || i == `IDX_SERIAL1_CONTROL0) begin
      hit = 1'b1;
    end
    if (i >= `IDX_ADC_RESULT_BASE && i <= `IDX_ADC_RESULT_LAST) begin
      hit = 1'b1;
    end
    addr_hit = hit && (a[`AXI_ADDR_W-1:10] == '0);
  endfunction : addr_hit

  // ****************************************************************
  // Peripheral configuration registers
  // ****************************************************************

  periph_cfg_s cfg_reg;
  periph_cfg_s cfg_next;

  // Stored as written; mode restrictions are left to software
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_go && wr_idx == `IDX_ADC_CONTROL) begin
      cfg_next.adc_control = wr_byte;
    end
    if (wr_go && wr_idx == `IDX_SERIAL1_MODE) begin
      cfg_next.serial1_mode = wr_byte;
    end
    if (wr_go && wr_idx == `IDX_SERIAL1_CONTROL0) begin
      cfg_next.serial1_control0 = wr_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= {`CFG_RESET, `CFG_RESET, `CFG_RESET};
    end else begin
      cfg_reg <= cfg_next;
    end
  end
  assign periph_cfg = cfg_reg;

  // ****************************************************************
  // Write channel
  // ****************************************************************

  wr_state_e wstate_reg;
  wr_state_e wstate_next;
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [`AXI_ADDR_W-1:0] waddr_reg;
  logic [`AXI_ADDR_W-1:0] waddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Address and data are taken independently and held until both are in
  assign awready = (wstate_reg == W_IDLE) && !aw_held_reg;
  assign wready = (wstate_reg == W_IDLE) && !w_held_reg;
  // Only byte lane 0 carries the 8-bit registers
  assign wr_go = (wstate_reg == W_IDLE) && aw_held_reg && w_held_reg
                 && wstrb_reg[0] && addr_hit(waddr_reg);
  assign wr_idx = addr_idx(waddr_reg);
  assign wr_byte = wdata_reg[7:0];

  always_comb begin
    wstate_next = wstate_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    case (wstate_reg)
      W_IDLE: begin
        if (awvalid && awready) begin
          aw_held_next = 1'b1;
          waddr_next = awaddr;
        end
        if (wvalid && wready) begin
          w_held_next = 1'b1;
          wdata_next = wdata;
          wstrb_next = wstrb;
        end
        if (aw_held_reg && w_held_reg) begin
          bresp_next = addr_hit(waddr_reg) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          wstate_next = W_RESP;
        end
      end
      W_RESP: begin
        if (bready) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wstate_next = W_IDLE;
        end
      end
      default: begin
        wstate_next = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wstate_reg <= W_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= `AXI_RESP_OKAY;
    end else begin
      wstate_reg <= wstate_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
    end
  end
  assign bvalid = (wstate_reg == W_RESP);
  assign bresp = bresp_reg;

  // ****************************************************************
  // Read channel
  // ****************************************************************

  rd_state_e rstate_reg;
  rd_state_e rstate_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // Read multiplexer; narrow registers sit in the low byte
  function automatic logic [7:0] read_mux(input logic [7:0] i);
    logic [7:0] v;
    logic [2:0] ch;
    v = 8'h00;
    ch = i[3:1];
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (i == DIR_IDX[p]) begin
        v = dir_rd[p];
      end
      if (i == DATA_IDX[p]) begin
        v = data_rd[p];
      end
    end
    if (i == `IDX_ADC_CONTROL) begin
      v = cfg_reg.adc_control;
    end
    if (i == `IDX_SERIAL1_MODE) begin
      v = cfg_reg.serial1_mode;
    end
    if (i == `IDX_SERIAL1_CONTROL0) begin
      v = cfg_reg.serial1_control0;
    end
    // Even index is the result byte, odd index its upper half which reads zero
    if (i >= `IDX_ADC_RESULT_BASE && i <= `IDX_ADC_RESULT_LAST && !i[0]) begin
      // Channels without pins give a fixed filler, not a measurement
      if (ch >= `ADC_CH_FIRST_MISSING && ch <= `ADC_CH_LAST_MISSING) begin
        v = `ADC_UNDEF_VALUE;
      end else begin
        v = adc_result_in[ch];
      end
    end
    read_mux = v;
  endfunction : read_mux

  assign arready = (rstate_reg == R_IDLE);

  always_comb begin
    rstate_next = rstate_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rstate_reg)
      R_IDLE: begin
        if (arvalid) begin
          if (addr_hit(araddr)) begin
            rdata_next = {24'h000000, read_mux(addr_idx(araddr))};
            rresp_next = `AXI_RESP_OKAY;
          end else begin
            rdata_next = 32'h00000000;
            rresp_next = `AXI_RESP_SLVERR;
          end
          rstate_next = R_RESP;
        end
      end
      R_RESP: begin
        if (rready) begin
          rstate_next = R_IDLE;
        end
      end
      default: begin
        rstate_next = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstate_reg <= R_IDLE;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `AXI_RESP_OKAY;
    end else begin
      rstate_reg <= rstate_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
  assign rvalid = (rstate_reg == R_RESP);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

endmodule : reduced_pin_port_config

// *** bench/rpp_assertions.sv ***
// Assertion checker for the reduced-pin port configuration block
`timescale 1ns/1ns
`include "rpp_params.svh"

module rpp_checker
  import rpp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [`AXI_ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pins
  input wire pin_drive_s [`NUM_PORTS-1:0] port_pins,
  input wire logic hold_acknowledge_out
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [`AXI_ADDR_W-1:0] rd_addr_reg;
  logic [`NUM_PORTS*8-1:0] oe_all;

  // Address of the read in flight, so its data can be judged
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_reg <= '0;
    end else if (arvalid && arready) begin
      rd_addr_reg <= araddr;
    end
  end

  // All enables flattened into one vector
  always_comb begin
    for (int i = 0; i < `NUM_PORTS; i++) begin
      oe_all[i*8 +: 8] = port_pins[i].oe;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_hold_ack_low;
    hold_acknowledge_out == 1'b0;
  endproperty
  a_hold_ack_low: assert property (p_hold_ack_low) else $error("hold ack driven");

  // Internal reset lags the pin by two edges, so pins stay inputs
  property p_reset_inputs;
    $rose(arst_n) |-> (oe_all == '0) [*2];
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("enable after reset");

  // Missing pins must never be driven, whatever is stored
  property p_missing_quiet;
    (port_pins[3].oe & ~`P3_PIN_MASK) == 8'h00 && (port_pins[4].oe & ~`P4_PIN_MASK) == 8'h00
    && (port_pins[6].oe & ~`P6_PIN_MASK) == 8'h00 && (port_pins[7].oe & ~`P7_PIN_MASK) == 8'h00
    && (port_pins[8].oe & ~`P8_PIN_MASK) == 8'h00;
  endproperty
  a_missing_quiet: assert property (p_missing_quiet) else $error("missing pin driven");

  property p_oe_on_write;
    $changed(oe_all) |-> $rose(bvalid);
  endproperty
  a_oe_on_write: assert property (p_oe_on_write) else $error("enable moved off write");

  property p_p3_upper_zero;
    rvalid && rd_addr_reg == 12'h024 |-> rdata[7:4] == 4'h0;
  endproperty
  a_p3_upper_zero: assert property (p_p3_upper_zero) else $error("port three upper set");

  property p_adc_filler;
    rvalid && rd_addr_reg inside {12'h098, 12'h0a0, 12'h0a8, 12'h0b0}
    |-> rdata == {24'h0, `ADC_UNDEF_VALUE};
  endproperty
  a_adc_filler: assert property (p_adc_filler) else $error("missing channel data");

  property p_read_answer;
    arvalid && arready |=> rvalid && rdata[31:8] == 24'h0;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_read_holds;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data dropped");

  property p_write_answer;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");

  c_write: cover property (awvalid && awready && wvalid && wready);
  c_p3_read: cover property (rvalid && rd_addr_reg == 12'h024);
  c_adc_filler: cover property (rvalid && rd_addr_reg == 12'h098);
endmodule : rpp_checker

bind reduced_pin_port_config rpp_checker chk_i (
  .mclk, .arst_n, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .araddr, .rvalid, .rready, .rdata, .port_pins, .hold_acknowledge_out
);

// *** bench/tb_reduced_pin_port_config.sv ***
// Self-checking testbench for the reduced-pin port configuration block
`timescale 1ns/1ns
`include "rpp_params.svh"

module tb_reduced_pin_port_config
  import rpp_pkg::*;
();
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [`AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_data;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, hold_acknowledge_out;
  logic [`NUM_PORTS-1:0][7:0] port_pin_in = '0;
  logic [7:0][7:0] adc_result_in = '0;
  pin_drive_s [`NUM_PORTS-1:0] port_pins;
  periph_cfg_s periph_cfg;
  int bad_count = 0, check_count = 0, cyc = 0;

  reduced_pin_port_config uut (
    .mclk, .arst_n, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .port_pin_in, .port_pins, .adc_result_in, .periph_cfg,
    .hold_acknowledge_out
  );

  // 50 MHz clock; the cycle ceiling cuts a hung handshake short
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare

  // Address and data offered together, each released when taken
  task automatic write_reg(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [11:0] a);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd_data = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : read_reg

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    read_reg(a);
    compare("read data", rd_data, {24'h0, e});
    compare("read resp", {30'h0, rs}, {30'h0, r});
  endtask : rdchk

  // Sampled a little after the edge so the register updates have landed
  task automatic chk_pins(input int p, input logic [7:0] oe, input logic [7:0] v);
    #1;
    compare("pin enable", {24'h0, port_pins[p].oe}, {24'h0, oe});
    compare("pin value", {24'h0, port_pins[p].value}, {24'h0, v});
  endtask : chk_pins

  task automatic test_reset();
    for (int p = 0; p < `NUM_PORTS; p++) begin
      chk_pins(p, 8'h00, 8'h00);
    end
    rdchk(ba(`IDX_P7_DIR), `DIR_RESET, `AXI_RESP_OKAY);
    rdchk(ba(`IDX_P3_DIR), `DIR_RESET, `AXI_RESP_OKAY);
    compare("hold ack", {31'h0, hold_acknowledge_out}, 32'h0);
    $display("test reset done");
  endtask : test_reset

  // Mixed directions: outputs show the latch, inputs show the pins
  task automatic test_direction();
    write_reg(ba(`IDX_P0_DIR), 8'h5a, 4'h1);
    write_reg(ba(`IDX_P0_DATA), 8'ha5, 4'h1);
    chk_pins(0, 8'h5a, 8'ha5);
    @(posedge mclk);
    port_pin_in[0] <= 8'hf0;
    rdchk(ba(`IDX_P0_DATA), 8'ha0, `AXI_RESP_OKAY);
    $display("test direction done");
  endtask : test_direction

  // Missing pins fixed to output by software yet never driven
  task automatic test_missing();
    logic [7:0] idx [4] = '{`IDX_P4_DIR, `IDX_P6_DIR, `IDX_P7_DIR, `IDX_P8_DIR};
    logic [7:0] msk [4] = '{`P4_PIN_MASK, `P6_PIN_MASK, `P7_PIN_MASK, `P8_PIN_MASK};
    int prt [4] = '{4, 6, 7, 8};
    for (int i = 0; i < 4; i++) begin
      write_reg(ba(idx[i]), 8'hff, 4'h1);
      chk_pins(prt[i], msk[i], 8'h00);
      rdchk(ba(idx[i]), 8'hff, `AXI_RESP_OKAY);
    end
    write_reg(ba(`IDX_P3_DIR), 8'hff, 4'h1);
    rdchk(ba(`IDX_P3_DIR), 8'h0f, `AXI_RESP_OKAY);
    chk_pins(3, `P3_PIN_MASK, 8'h00);
    write_reg(ba(`IDX_P7_DIR), 8'h78, 4'h1);
    chk_pins(7, 8'h00, 8'h00);
    rdchk(ba(`IDX_P7_DIR), 8'h78, `AXI_RESP_OKAY);
    $display("test missing pins done");
  endtask : test_missing

  task automatic test_config();
    logic [2:0] sel [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    for (int i = 0; i < 4; i++) begin
      write_reg(ba(`IDX_ADC_CONTROL), {5'h0, sel[i]}, 4'h1);
      #1;
      compare("adc control", {24'h0, periph_cfg.adc_control}, {29'h0, sel[i]});
    end
    write_reg(ba(`IDX_SERIAL1_MODE), 8'h05, 4'h1);
    #1;
    compare("serial mode", {24'h0, periph_cfg.serial1_mode}, 32'h05);
    write_reg(ba(`IDX_SERIAL1_CONTROL0), 8'h04, 4'h1);
    rdchk(ba(`IDX_SERIAL1_CONTROL0), 8'h04, `AXI_RESP_OKAY);
    $display("test config done");
  endtask : test_config

  // Bonded channels read their input, missing ones read the filler
  task automatic test_adc();
    logic [7:0] e;
    @(posedge mclk);
    for (int c = 0; c < 8; c++) begin
      adc_result_in[c] <= 8'h90 + 8'(c);
    end
    for (int c = 0; c < 8; c++) begin
      e = (c >= 3 && c <= 6) ? `ADC_UNDEF_VALUE : 8'h90 + 8'(c);
      rdchk(ba(`IDX_ADC_RESULT_BASE + 8'(2 * c)), e, `AXI_RESP_OKAY);
    end
    $display("test adc done");
  endtask : test_adc

  task automatic test_bus_errors();
    rdchk(12'hc00, 8'h00, `AXI_RESP_SLVERR);
    write_reg(12'hc00, 8'hff, 4'h1);
    compare("write resp", {30'h0, rs}, {30'h0, `AXI_RESP_SLVERR});
    write_reg(ba(`IDX_P5_DIR), 8'hff, 4'h0);
    compare("write resp", {30'h0, rs}, {30'h0, `AXI_RESP_OKAY});
    rdchk(ba(`IDX_P5_DIR), 8'h00, `AXI_RESP_OKAY);
    chk_pins(5, 8'h00, 8'h00);
    $display("test bus errors done");
  endtask : test_bus_errors

  // Reset in mid-run with port 0 outputs enabled; every port 0 enable must be clear three cycles after release
  task automatic test_midreset();
    write_reg(ba(`IDX_P0_DIR), 8'hff, 4'h1);
    compare("write resp", {30'h0, rs}, {30'h0, `AXI_RESP_OKAY});
    chk_pins(0, 8'hff, 8'ha5);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_pins(0, 8'h00, 8'h00);
    rdchk(ba(`IDX_P0_DIR), `DIR_RESET, `AXI_RESP_OKAY);
    $display("test mid-run reset done");
  endtask : test_midreset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Reset held ten cycles, then requests wait out the synchroniser
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    test_reset();
    test_direction();
    test_missing();
    test_config();
    test_adc();
    test_bus_errors();
    test_midreset();
    tally_and_finish();
  end
endmodule : tb_reduced_pin_port_config
